// ### bench/tb.sv
// Self-checking testbench of the thermal fan register bank.
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk, rst_n, int_request, therm_n_pin, general_input_pin, ok, seen;
  tfc_pkg::tfc_req_s req;
  tfc_pkg::tfc_meas_s meas;
  tfc_pkg::tfc_trip_s trip_active;
  logic [7:0] rdata, fan_speed_analog_out, v;
  logic rvalid, int_n, fan_off_o, fan_off_oe_n, run_enable, input_level, soft_reset_pulse;
  logic [31:0] limits;
  int n_fail = 0;
  int check_count = 0;
  logic [7:0] adr [14] = '{8'h13, 8'h14, 8'h15, 8'h17, 8'h18, 8'h19, 8'h26, 8'h27,
    8'h37, 8'h38, 8'h39, 8'h3A, 8'h40, 8'h50};
  logic [7:0] dflt [14] = '{8'h7F, 8'h64, 8'h00, 8'h46, 8'h64, 8'h00, 8'h00, 8'h00,
    8'h7F, 8'h80, 8'h7F, 8'h80, 8'h21, 8'h00};

  tfc_host host (.mclk(mclk), .req(req), .rdata(rdata), .rvalid(rvalid));

  tfc_regs uut (.mclk(mclk), .rst_n(rst_n), .req(req), .rdata(rdata), .rvalid(rvalid),
    .meas(meas), .int_request(int_request), .therm_n_pin(therm_n_pin),
    .general_input_pin(general_input_pin), .int_n(int_n), .fan_off_o(fan_off_o),
    .fan_off_oe_n(fan_off_oe_n), .fan_speed_analog_out(fan_speed_analog_out),
    .run_enable(run_enable), .input_level(input_level),
    .soft_reset_pulse(soft_reset_pulse), .trip_active(trip_active), .limits(limits));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop();
    if (n_fail == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // A read that never answers ends the run at once.
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    host.rd(a, v, ok);
    if (ok !== 1'b1) begin
      n_fail++;
      report_and_stop();
    end else begin
      chk(32'(v), 32'(exp));
    end
  endtask

  // Derived outputs lag the register by one cycle and the pins by a synchroniser.
  task automatic settle(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  initial begin
    rst_n = 1'b0;
    int_request = 1'b0;
    therm_n_pin = 1'b1;
    general_input_pin = 1'b0;
    meas = '0;
    seen = 1'b0;
    repeat (8) @(posedge mclk);
    rst_n <= 1'b1;
    settle(3);
    chk(32'(trip_active), 32'h4664);
    chk(limits, 32'h7F807F80);
    chk(32'({run_enable, fan_off_oe_n, int_n, fan_off_o}), 32'hE);
    chk(32'(fan_speed_analog_out), 32'h0);
    for (int i = 0; i < 14; i++) rchk(adr[i], dflt[i]);
    // Load the measurements first, so the writes after them must leave them untouched.
    @(posedge mclk) meas <= '{update: 1'b1, remote: 8'hE7, internal: 8'h2A};
    @(posedge mclk) meas.update <= 1'b0;
    for (int i = 3; i < 8; i++) host.wr(adr[i], 8'hFF);
    rchk(8'h17, 8'h46);
    rchk(8'h18, 8'h64);
    rchk(8'h26, 8'hE7);
    rchk(8'h27, 8'h2A);
    rchk(8'h19, 8'hFF);
    host.wr(8'h19, 8'h55);
    host.wr(8'h37, 8'h50);
    host.wr(8'h38, 8'h10);
    host.wr(8'h39, 8'h60);
    host.wr(8'h3A, 8'hF0);
    settle(3);
    chk(32'(fan_speed_analog_out), 32'h55);
    chk(limits, 32'h501060F0);
    @(posedge mclk) int_request <= 1'b1;
    settle(3);
    chk(32'(int_n), 32'h1);
    host.wr(8'h40, 8'h23);
    settle(3);
    chk(32'(int_n), 32'h0);
    @(posedge mclk) int_request <= 1'b0;
    settle(3);
    chk(32'(int_n), 32'h1);
    host.wr(8'h40, 8'hC4);
    settle(4);
    chk(32'({run_enable, fan_off_oe_n, input_level}), 32'h1);
    rchk(8'h40, 8'h40);
    @(posedge mclk) general_input_pin <= 1'b1;
    settle(4);
    chk(32'(input_level), 32'h0);
    @(posedge mclk) therm_n_pin <= 1'b0;
    settle(6);
    chk(32'(fan_off_oe_n), 32'h1);
    rchk(8'h40, 8'h60);
    @(posedge mclk) therm_n_pin <= 1'b1;
    settle(6);
    chk(32'(fan_off_oe_n), 32'h0);
    rchk(8'h40, 8'h40);
    host.wr(8'h13, 8'h50);
    host.wr(8'h14, 8'h70);
    settle(3);
    chk(32'(trip_active), 32'h4664);
    host.wr(8'h40, 8'h29);
    settle(3);
    chk(32'(trip_active), 32'h5070);
    host.wr(8'h13, 8'h10);
    host.wr(8'h14, 8'h10);
    rchk(8'h13, 8'h50);
    rchk(8'h14, 8'h70);
    host.wr(8'h40, 8'h21);
    rchk(8'h40, 8'h29);
    host.wr(8'h40, 8'h12);
    for (int i = 0; i < 3; i++) begin
      #1;
      seen = seen | (soft_reset_pulse === 1'b1);
      @(posedge mclk);
    end
    chk(32'(seen), 32'h1);
    rchk(8'h40, 8'h29);
    chk(limits, 32'h501060F0);
    @(posedge mclk) rst_n <= 1'b0;
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    settle(2);
    rchk(8'h40, 8'h21);
    rchk(8'h13, 8'h7F);
    report_and_stop();
  end
endmodule
`default_nettype wire

// ### bench/tfc_host.sv
// Management bus host model that issues register reads and writes to the bank.
`include "tfc_params.svh"
`default_nettype none
module tfc_host (
  // Clock
  input wire logic mclk,
  // Register port
  output tfc_pkg::tfc_req_s req,
  input wire logic [7:0] rdata,
  input wire logic rvalid
);
  timeunit 1ns;
  timeprecision 1ps;

  initial req = '0;

  ////////////////////////////////////////////////////////////////////////////////
  // A write is held for exactly one taking edge, then released.
  // The factory test location is silently skipped, so no test can disturb it.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    if (a !== `TFC_OFS_FACTORY_TEST) begin
      @(posedge mclk);
      req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(posedge mclk);
      req <= '0;
    end
  endtask

  // Read data is taken at the edge where rvalid is seen high, within four edges.
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
    ok = 1'b0;
    d = 8'h00;
    @(posedge mclk);
    req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge mclk);
    req <= '0;
    for (int i = 0; i < 4 && ok !== 1'b1; i++) begin
      #1;
      if (rvalid === 1'b1) begin
        ok = 1'b1;
        d = rdata;
      end else begin
        @(posedge mclk);
      end
    end
  endtask
endmodule
`default_nettype wire

// ### pkg/tfc_params.svh
// Offsets, field positions and reset values of the thermal fan register bank.
// Functional notes
// - Internal trip programmable, 127, locked by bit3
// - Remote trip programmable, 100, locked by bit3
// - Fixed internal trip 70, inactive once locked
// - Fixed remote trip 100, read only
// - Fan speed code resets zero, drives output
// - Remote high/low limits default +127/-128
// - Internal high/low limits default +127/-128
// - Bit0 runs monitoring, clear means standby
// - Bit1 gates interrupt output, resets cleared
// - Bits 2 and 7 read zero
// - Bit3 write once until reset pin
// - Locked: fixed remote trip stops acting
// - Soft reset restores config, status, mask
// - Soft reset bit self clears, reads zero
// - Bit5 floats fan-off pin, clear drives low
// - Overtemperature forces bit5, restores on negation
// - Bit5 reads driver state not pin
// - Bit6 inverts general input before detection
// - Configuration resets to 21 hex
`ifndef TFC_PARAMS_SVH
`define TFC_PARAMS_SVH
`define TFC_OFS_INT_TRIP_PROG 8'h13
`define TFC_OFS_REM_TRIP_PROG 8'h14
`define TFC_OFS_FACTORY_TEST 8'h15
`define TFC_OFS_INT_TRIP_FIX 8'h17
`define TFC_OFS_REM_TRIP_FIX 8'h18
`define TFC_OFS_FAN_SPEED 8'h19
`define TFC_OFS_REM_TEMP 8'h26
`define TFC_OFS_INT_TEMP 8'h27
`define TFC_OFS_REM_HIGH 8'h37
`define TFC_OFS_REM_LOW 8'h38
`define TFC_OFS_INT_HIGH 8'h39
`define TFC_OFS_INT_LOW 8'h3A
`define TFC_OFS_CONFIG 8'h40
`define TFC_RST_INT_TRIP_PROG 8'h7F
`define TFC_RST_REM_TRIP_PROG 8'h64
`define TFC_VAL_INT_TRIP_FIX 8'h46
`define TFC_VAL_REM_TRIP_FIX 8'h64
`define TFC_RST_FAN_SPEED 8'h00
`define TFC_RST_HIGH_LIMIT 8'h7F
`define TFC_RST_LOW_LIMIT 8'h80
`define TFC_RST_FACTORY_TEST 8'h00
`define TFC_RST_TEMP 8'h00
`define TFC_RST_CONFIG 8'h21
`define TFC_CFG_RUN 0
`define TFC_CFG_INT_EN 1
`define TFC_CFG_LOCK 3
`define TFC_CFG_SOFT_RST 4
`define TFC_CFG_FAN_OFF 5
`define TFC_CFG_INVERT 6
`endif

// ### pkg/tfc_pkg.sv
// Types shared by the thermal fan register bank.
`default_nettype none
package tfc_pkg;
  typedef logic [7:0] tfc_byte_t;

  // One register access from the management bus engine.
  typedef struct packed {
    logic wr;
    logic rd;
    tfc_byte_t addr;
    tfc_byte_t wdata;
  } tfc_req_s;

  // Temperatures delivered by the conversion engine.
  typedef struct packed {
    logic update;
    tfc_byte_t remote;
    tfc_byte_t internal;
  } tfc_meas_s;

  // Trip points that the overtemperature logic must use.
  typedef struct packed {
    tfc_byte_t internal;
    tfc_byte_t remote;
  } tfc_trip_s;
endpackage
`default_nettype wire

// ### rtl/tfc_regs.sv
// Value and configuration register bank of the thermal fan controller.
`include "tfc_params.svh"
`default_nettype none
module tfc_regs (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Register access
  input wire tfc_pkg::tfc_req_s req,
  output logic [7:0] rdata,
  output logic rvalid,
  // Measurements and status from the monitoring engine
  input wire tfc_pkg::tfc_meas_s meas,
  input wire logic int_request,
  // Pins
  input wire logic therm_n_pin,
  input wire logic general_input_pin,
  output logic int_n,
  output logic fan_off_o,
  output logic fan_off_oe_n,
  output logic [7:0] fan_speed_analog_out,
  // Control towards the monitoring engine
  output logic run_enable,
  output logic input_level,
  output logic soft_reset_pulse,
  output tfc_pkg::tfc_trip_s trip_active,
  output logic [31:0] limits
);

  //////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers.

  logic [1:0] therm_sync;
  logic [1:0] gpi_sync;
  logic therm_prev;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      therm_sync <= 2'h3;
      gpi_sync <= 2'h0;
      therm_prev <= 1'h0;
    end else begin
      therm_sync <= {therm_sync[0], therm_n_pin};
      gpi_sync <= {gpi_sync[0], general_input_pin};
      therm_prev <= ~therm_sync[1];
    end
  end

  wire therm_on = ~therm_sync[1];
  wire therm_rise = therm_on & ~therm_prev;
  wire therm_fall = ~therm_on & therm_prev;

  //////////////////////////////////////////////////////////////////////////////
  // Address decode.

  wire [7:0] a = req.addr;
  wire w = req.wr;
  wire [7:0] d = req.wdata;
  wire hit_int_trip = a == `TFC_OFS_INT_TRIP_PROG;
  wire hit_rem_trip = a == `TFC_OFS_REM_TRIP_PROG;
  wire hit_test = a == `TFC_OFS_FACTORY_TEST;
  wire hit_int_fix = a == `TFC_OFS_INT_TRIP_FIX;
  wire hit_rem_fix = a == `TFC_OFS_REM_TRIP_FIX;
  wire hit_fan = a == `TFC_OFS_FAN_SPEED;
  wire hit_rem_temp = a == `TFC_OFS_REM_TEMP;
  wire hit_int_temp = a == `TFC_OFS_INT_TEMP;
  wire hit_rem_high = a == `TFC_OFS_REM_HIGH;
  wire hit_rem_low = a == `TFC_OFS_REM_LOW;
  wire hit_int_high = a == `TFC_OFS_INT_HIGH;
  wire hit_int_low = a == `TFC_OFS_INT_LOW;
  wire hit_cfg = a == `TFC_OFS_CONFIG;

  //////////////////////////////////////////////////////////////////////////////
  // Value registers.

  logic [7:0] int_trip;
  logic [7:0] rem_trip;
  logic [7:0] test_reg;
  logic [7:0] rem_temp;
  logic [7:0] int_temp;
  logic [7:0] rem_high;
  logic [7:0] rem_low;
  logic [7:0] int_high;
  logic [7:0] int_low;
  logic lock;

  // Writes to the trip points are dropped silently once locked.
  wire wr_int_trip = w & hit_int_trip & ~lock;
  wire wr_rem_trip = w & hit_rem_trip & ~lock;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      int_trip <= `TFC_RST_INT_TRIP_PROG;
      rem_trip <= `TFC_RST_REM_TRIP_PROG;
      test_reg <= `TFC_RST_FACTORY_TEST;
      fan_speed_analog_out <= `TFC_RST_FAN_SPEED;
      rem_high <= `TFC_RST_HIGH_LIMIT;
      rem_low <= `TFC_RST_LOW_LIMIT;
      int_high <= `TFC_RST_HIGH_LIMIT;
      int_low <= `TFC_RST_LOW_LIMIT;
    end else begin
      if (wr_int_trip) int_trip <= d;
      if (wr_rem_trip) rem_trip <= d;
      // The test location is kept only as storage; it controls nothing here.
      if (w && hit_test) test_reg <= d;
      if (w && hit_fan) fan_speed_analog_out <= d;
      if (w && hit_rem_high) rem_high <= d;
      if (w && hit_rem_low) rem_low <= d;
      if (w && hit_int_high) int_high <= d;
      if (w && hit_int_low) int_low <= d;
    end
  end

  // Host writes never reach the measured values.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      rem_temp <= `TFC_RST_TEMP;
      int_temp <= `TFC_RST_TEMP;
    end else if (meas.update) begin
      rem_temp <= meas.remote;
      int_temp <= meas.internal;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Configuration register.

  logic run;
  logic int_en;
  logic fan_off;
  logic fan_off_saved;
  logic invert;

  wire cfg_wr = w & hit_cfg;
  wire soft_rst = cfg_wr & d[`TFC_CFG_SOFT_RST];
  wire [7:0] cfg_rst = `TFC_RST_CONFIG;

  // A soft reset takes the power-up value; the lock leaves only by the reset pin.
  wire next_run = soft_rst ? cfg_rst[`TFC_CFG_RUN] : d[`TFC_CFG_RUN];
  wire next_int_en = soft_rst ? cfg_rst[`TFC_CFG_INT_EN] : d[`TFC_CFG_INT_EN];
  wire next_invert = soft_rst ? cfg_rst[`TFC_CFG_INVERT] : d[`TFC_CFG_INVERT];
  wire next_lock = lock | (~soft_rst & d[`TFC_CFG_LOCK]);
  wire next_fan_req = soft_rst ? cfg_rst[`TFC_CFG_FAN_OFF] : d[`TFC_CFG_FAN_OFF];

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      run <= 1'h1;
      int_en <= 1'h0;
      lock <= 1'h0;
      invert <= 1'h0;
    end else if (cfg_wr) begin
      run <= next_run;
      int_en <= next_int_en;
      lock <= next_lock;
      invert <= next_invert;
    end
  end

  // While overtemperature holds, host writes go to the saved copy so that the
  // value restored on negation is the latest one software asked for.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      fan_off <= 1'h1;
      fan_off_saved <= 1'h1;
    end else if (therm_rise) begin
      fan_off_saved <= cfg_wr ? next_fan_req : fan_off;
      fan_off <= 1'h1;
    end else if (therm_on) begin
      if (cfg_wr) fan_off_saved <= next_fan_req;
      fan_off <= 1'h1;
    end else if (therm_fall) begin
      fan_off <= cfg_wr ? next_fan_req : fan_off_saved;
    end else if (cfg_wr) begin
      fan_off <= next_fan_req;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Pins and control outputs.

  // Before locking, whichever of fixed and programmed trip is lower acts first.
  wire int_fix_lower = $signed(`TFC_VAL_INT_TRIP_FIX) < $signed(int_trip);
  wire rem_fix_lower = $signed(`TFC_VAL_REM_TRIP_FIX) < $signed(rem_trip);
  wire [7:0] next_int_act = (!lock && int_fix_lower) ? `TFC_VAL_INT_TRIP_FIX : int_trip;
  wire [7:0] next_rem_act = (!lock && rem_fix_lower) ? `TFC_VAL_REM_TRIP_FIX : rem_trip;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      int_n <= 1'h1;
      fan_off_o <= 1'h0;
      fan_off_oe_n <= 1'h1;
      run_enable <= 1'h1;
      input_level <= 1'h0;
      soft_reset_pulse <= 1'h0;
      trip_active <= '0;
      limits <= '0;
    end else begin
      int_n <= ~(int_request & int_en);
      fan_off_o <= 1'h0;
      fan_off_oe_n <= fan_off;
      run_enable <= run;
      input_level <= gpi_sync[1] ^ invert;
      // The engine clears status and mask and re-arms the interrupt only.
      soft_reset_pulse <= soft_rst;
      trip_active <= '{internal: next_int_act, remote: next_rem_act};
      limits <= {rem_high, rem_low, int_high, int_low};
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Read path, one cycle after the request.

  wire [7:0] cfg_read = {1'h0, invert, fan_off, 1'h0, lock, 1'h0, int_en, run};
  wire [7:0] next_rdata =
    hit_int_trip ? int_trip :
    hit_rem_trip ? rem_trip :
    hit_test ? test_reg :
    hit_int_fix ? `TFC_VAL_INT_TRIP_FIX :
    hit_rem_fix ? `TFC_VAL_REM_TRIP_FIX :
    hit_fan ? fan_speed_analog_out :
    hit_rem_temp ? rem_temp :
    hit_int_temp ? int_temp :
    hit_rem_high ? rem_high :
    hit_rem_low ? rem_low :
    hit_int_high ? int_high :
    hit_int_low ? int_low :
    hit_cfg ? cfg_read : 8'h00;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      rdata <= 8'h00;
      rvalid <= 1'h0;
    end else begin
      rvalid <= req.rd;
      if (req.rd) rdata <= next_rdata;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Checks.

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  int_trip_lock_a: assert property (lock && w && hit_int_trip |=> $stable(int_trip))
    else $error("Internal trip changed while locked.");
  rem_trip_lock_a: assert property (lock && w && hit_rem_trip |=> $stable(rem_trip))
    else $error("Remote trip changed while locked.");
  fixed_read_a: assert property (req.rd && hit_int_fix |=> rdata == 8'h46 && rvalid)
    else $error("Fixed internal trip read wrong.");
  remote_fixed_a: assert property (req.rd && hit_rem_fix |=> rdata == 8'h64)
    else $error("Fixed remote trip read wrong.");
  fan_code_a: assert property (w && hit_fan |=> fan_speed_analog_out == $past(d))
    else $error("Fan code not written.");
  limit_write_a: assert property (w && hit_rem_low |=> ##1 limits[23:16] == $past(d, 2))
    else $error("Remote low limit not forwarded.");
  int_limit_a: assert property (w && hit_int_high |=> ##1 limits[15:8] == $past(d, 2))
    else $error("Internal high limit not forwarded.");
  run_follow_a: assert property (cfg_wr && !soft_rst |=> ##1 run_enable == $past(d[0], 2))
    else $error("Run output does not follow bit 0.");
  int_gate_a: assert property (!int_en |=> int_n)
    else $error("Interrupt driven while disabled.");
  reserved_zero_a: assert property (rvalid && $past(hit_cfg) |-> !rdata[7] && !rdata[2])
    else $error("Reserved configuration bit read as one.");
  lock_hold_a: assert property (lock |=> lock)
    else $error("Lock cleared without reset pin.");
  lock_trip_a: assert property (lock ##1 lock |-> trip_active.remote == $past(rem_trip))
    else $error("Fixed remote trip acts while locked.");
  soft_reset_a: assert property (
    soft_rst |=> cfg_read == (`TFC_RST_CONFIG | {4'h0, lock, 3'h0}))
    else $error("Soft reset did not restore configuration.");
  self_clear_a: assert property (rvalid && $past(hit_cfg) |-> !rdata[4])
    else $error("Soft reset bit read as one.");
  therm_force_a: assert property (therm_rise |=> fan_off ##1 fan_off_oe_n)
    else $error("Fan-off bit not forced by overtemperature.");
  therm_restore_a: assert property (
    therm_fall && !cfg_wr |=> fan_off == $past(fan_off_saved))
    else $error("Fan-off bit not restored.");
  input_invert_a: assert property (
    ##2 input_level == ($past(gpi_sync[1]) ^ $past(invert)))
    else $error("General input polarity wrong.");

  //////////////////////////////////////////////////////////////////////////////
  // Read-back checks: each trip, fan, temperature and limit location returns what it held at the request.

  read_int_trip_a: assert property (req.rd && hit_int_trip |=> rdata == $past(int_trip))
    else $error("Internal trip read back wrong.");
  read_rem_trip_a: assert property (req.rd && hit_rem_trip |=> rdata == $past(rem_trip))
    else $error("Remote trip read back wrong.");
  read_fan_code_a: assert property (
    req.rd && hit_fan |=> rdata == $past(fan_speed_analog_out))
    else $error("Fan code read back wrong.");
  read_rem_temp_a: assert property (req.rd && hit_rem_temp |=> rdata == $past(rem_temp))
    else $error("Remote temperature read back wrong.");
  read_int_temp_a: assert property (req.rd && hit_int_temp |=> rdata == $past(int_temp))
    else $error("Internal temperature read back wrong.");
  read_rem_high_a: assert property (req.rd && hit_rem_high |=> rdata == $past(rem_high))
    else $error("Remote high limit read back wrong.");
  read_rem_low_a: assert property (req.rd && hit_rem_low |=> rdata == $past(rem_low))
    else $error("Remote low limit read back wrong.");
  read_int_high_a: assert property (req.rd && hit_int_high |=> rdata == $past(int_high))
    else $error("Internal high limit read back wrong.");
  read_int_low_a: assert property (req.rd && hit_int_low |=> rdata == $past(int_low))
    else $error("Internal low limit read back wrong.");
  fan_bit_read_a: assert property (req.rd && hit_cfg |=> rdata[5] == $past(fan_off))
    else $error("Fan-off bit read does not show the driver.");
  rdata_hold_a: assert property (!req.rd |=> $stable(rdata))
    else $error("Read data changed without a read.");

  // Storage checks: values change only through their own write or load.

  temp_hold_a: assert property (!meas.update |=> $stable(rem_temp) && $stable(int_temp))
    else $error("Temperature value changed without a load.");
  temp_load_a: assert property (
    meas.update |=> rem_temp == $past(meas.remote) && int_temp == $past(meas.internal))
    else $error("Temperature value not loaded.");
  fan_hold_a: assert property (!(w && hit_fan) |=> $stable(fan_speed_analog_out))
    else $error("Fan code changed without a write.");
  int_trip_open_a: assert property (!lock && w && hit_int_trip |=> int_trip == $past(d))
    else $error("Internal trip not written while unlocked.");
  rem_trip_open_a: assert property (!lock && w && hit_rem_trip |=> rem_trip == $past(d))
    else $error("Remote trip not written while unlocked.");
  run_hold_a: assert property (!cfg_wr |=> $stable(run))
    else $error("Run bit changed without a write.");
  lock_set_a: assert property (cfg_wr && !soft_rst && d[3] |=> lock)
    else $error("Lock bit not set by a write.");
  lock_stays_clear_a: assert property (!lock && !(cfg_wr && d[3]) |=> !lock)
    else $error("Lock bit set without a write.");
  soft_limits_a: assert property (
    soft_rst |=> $stable(rem_high) && $stable(rem_low) && $stable(int_high) && $stable(int_low))
    else $error("Soft reset disturbed a limit.");

  // Trip selection: a fixed point acts only while unlocked, and the lower value wins.

  int_act_fix_a: assert property (
    !lock && $signed(int_trip) > 8'sh46 |=> trip_active.internal == 8'h46)
    else $error("Fixed internal trip not acting before lock.");
  int_act_prog_a: assert property (
    !lock && $signed(int_trip) <= 8'sh46 |=> trip_active.internal == $past(int_trip))
    else $error("Programmed internal trip not acting before lock.");
  int_act_lock_a: assert property (lock |=> trip_active.internal == $past(int_trip))
    else $error("Fixed internal trip acts while locked.");
  rem_act_fix_a: assert property (
    !lock && $signed(rem_trip) > 8'sh64 |=> trip_active.remote == 8'h64)
    else $error("Fixed remote trip not acting before lock.");
  rem_act_prog_a: assert property (
    !lock && $signed(rem_trip) <= 8'sh64 |=> trip_active.remote == $past(rem_trip))
    else $error("Programmed remote trip not acting before lock.");

  // Pins and control outputs.

  fan_float_a: assert property (fan_off |=> fan_off_oe_n)
    else $error("Fan-off pin driven while the bit is set.");
  fan_drive_a: assert property (!fan_off |=> !fan_off_oe_n && !fan_off_o)
    else $error("Fan-off pin not driven low while the bit is clear.");
  fan_write_a: assert property (
    cfg_wr && !soft_rst && !therm_on && !therm_prev |=> fan_off == $past(d[5]))
    else $error("Fan-off bit not written.");
  fan_forced_a: assert property (therm_on |=> fan_off)
    else $error("Fan-off bit not held during overtemperature.");
  int_enable_a: assert property (int_en && int_request |=> !int_n)
    else $error("Enabled interrupt not driven.");
  run_standby_a: assert property (!run |=> !run_enable)
    else $error("Run output high in standby.");
  soft_pulse_a: assert property (soft_rst |=> soft_reset_pulse)
    else $error("Soft reset pulse missing.");
  soft_pulse_only_a: assert property (!soft_rst |=> !soft_reset_pulse)
    else $error("Soft reset pulse without a request.");

  lock_seen_c: cover property (cfg_wr && d[3] ##1 lock);
  therm_cycle_c: cover property (therm_rise ##[1:20] therm_fall);
  soft_reset_c: cover property (soft_rst ##1 soft_reset_pulse);
  int_fire_c: cover property (int_en && int_request ##1 !int_n);
  fan_restore_c: cover property (therm_fall && !fan_off_saved);

endmodule
`default_nettype wire
